/* verilog/pscsi_target.sv */
// Target end: phase, data, parity and P_CRCA driving with an AHB-Lite register port.
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pscsi_map.svh"
// Summary of operation
// - Data groups: P_CRCA marks pad/pCRC, negated data.
// - IU mode: unused DT phases keep P_CRCA negated.
// - Write flow control: flag last IU in OUT.
// - Read streaming: flag last IU in IN.
// - P1 gives odd parity over upper byte.
// - P1 undriven in control and narrow ST phases.
// - Data groups: P1 negated in DT, ignored.
// - IU mode: P1 negated in DT, ignored.
// - Assert by driving true; OR-tied only released.
// - Non-OR-tied lines may be actively negated.
// - Data bit true reads one, false zero.
// - BSY, SEL, RST use OR-tied drivers.
// - Other lines have one driver at once.
// - Never drive P_CRCA or P1 false in arbitration.
// - Bus ID from binary jumpers, width dependent.
// - Arbitrate on own ID line, fixed priority.
// - Outside DT phases, P_CRCA is low byte parity; DT without DG/IU drives it negated.
module pscsi_target import pscsi_pkg::*; #(
   parameter int ARB_CYCLES = (`PSCSI_ARB_NS + `PSCSI_CLK_NS - 1) / `PSCSI_CLK_NS
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Interrupt and straps
   output logic irq,
   input wire logic [3:0] id_jumper,
   // Bus
   pscsi_if.tgt link
);
   // ******************************************
   // Register port
   // ******************************************
   logic acc;
   logic wr_q;
   logic [7:0] wa_q;
   logic [6:0] ctrl_q;
   pscsi_phase_type phase_q;
   logic [17:0] tx_q;
   logic [16:0] rx_q;
   logic [6:0] stat_q;
   logic [6:0] mask_q;
   logic [6:0] ev;
   logic [31:0] rd;
   pscsi_xfer_type xs_q;
   logic [15:0] arb_cnt_q;
   logic [3:0] id;
   pscsi_bus_type s1_q, s2_q, s3_q, f_q, o_q, oe_q, o_d, oe_d;
   logic [3:0] j1_q, j2_q, j3_q, jf_q;
   logic rst_seen_q;
   logic wide, dg, iu, in_ph, dt_ph, data_ph, act_ph, arb_ph, perr, tx_wr;

   assign acc = hsel & htrans[1] & hready;
   assign tx_wr = wr_q && wa_q == `PSCSI_TX_OFS;

   always_comb begin
      case (haddr[7:0])
         `PSCSI_CTRL_OFS: rd = {25'h000_0000, ctrl_q};
         `PSCSI_CMD_OFS: rd = {28'h000_0000, phase_q};
         `PSCSI_TX_OFS: rd = {14'h0000, tx_q};
         `PSCSI_RX_OFS: rd = {15'h0000, rx_q};
         `PSCSI_STATUS_OFS: rd = {30'h0000_0000, arb_cnt_q != 16'h0000, xs_q != X_IDLE};
         `PSCSI_ISTAT_OFS: rd = {25'h000_0000, stat_q};
         `PSCSI_IMASK_OFS: rd = {25'h000_0000, mask_q};
         `PSCSI_ID_OFS: rd = {28'h000_0000, id};
         default: rd = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_q <= acc & hwrite;
         if (acc) begin
            wa_q <= haddr[7:0];
         end
         if (acc && !hwrite) begin
            hrdata <= rd;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `PSCSI_CTRL_RESET;
         mask_q <= `PSCSI_MASK_RESET;
      end else if (wr_q) begin
         if (wa_q == `PSCSI_CTRL_OFS) begin
            ctrl_q <= hwdata[6:0];
         end
         if (wa_q == `PSCSI_IMASK_OFS) begin
            mask_q <= hwdata[6:0];
         end
      end
   end

   // Set wins over a clear arriving in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= 7'h00;
         irq <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~((wr_q && wa_q == `PSCSI_ISTAT_OFS) ? hwdata[6:0] : 7'h00)) | ev;
         irq <= |(stat_q & mask_q);
      end
   end

   // ******************************************
   // Input filtering
   // ******************************************
   // A line counts as changed only once the second and third stages agree.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         f_q <= '0;
         j1_q <= 4'h0;
         j2_q <= 4'h0;
         j3_q <= 4'h0;
         jf_q <= 4'h0;
      end else begin
         s1_q <= link.bus;
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
         j1_q <= id_jumper;
         j2_q <= j1_q;
         j3_q <= j2_q;
         jf_q <= ((j2_q ~^ j3_q) & j3_q) | ((j2_q ^ j3_q) & jf_q);
      end
   end

   assign wide = ctrl_q[`PSCSI_CTRL_WIDE];
   assign dg = ctrl_q[`PSCSI_CTRL_DG];
   assign iu = ctrl_q[`PSCSI_CTRL_IU];
   assign id = wide ? jf_q : {1'b0, jf_q[2:0]};
   assign arb_ph = phase_q == PH_ARB;
   assign act_ph = phase_q != PH_BUS_FREE && !arb_ph;
   assign dt_ph = phase_q == PH_DT_IN || phase_q == PH_DT_OUT;
   assign data_ph = dt_ph || phase_q == PH_ST_IN || phase_q == PH_ST_OUT;
   assign in_ph = phase_q == PH_MSG_IN || phase_q == PH_STATUS || phase_q == PH_ST_IN ||
                  phase_q == PH_DT_IN;
   // Low byte parity is not checkable in DT phases, where P_CRCA is ours.
   assign perr = (!dt_ph && pscsi_par_bad(f_q.db[7:0], f_q.p_crca)) ||
                 (wide && data_ph && !(dt_ph && (dg || iu)) &&
                  pscsi_par_bad(f_q.db[15:8], f_q.p1));

   // ******************************************
   // Phase, arbitration and transfers
   // ******************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q <= PH_BUS_FREE;
         arb_cnt_q <= 16'h0000;
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= f_q.rst;
         if (f_q.rst) begin
            phase_q <= PH_BUS_FREE;
            arb_cnt_q <= 16'h0000;
         end else if (arb_cnt_q != 16'h0000) begin
            arb_cnt_q <= arb_cnt_q - 16'h0001;
            if (arb_cnt_q == 16'h0001 && pscsi_outranked(f_q.db, id)) begin
               phase_q <= PH_BUS_FREE;
            end
         end else if (wr_q && wa_q == `PSCSI_CMD_OFS && xs_q == X_IDLE) begin
            phase_q <= pscsi_phase_type'(hwdata[3:0]);
            if (pscsi_phase_type'(hwdata[3:0]) == PH_ARB) begin
               arb_cnt_q <= 16'(ARB_CYCLES);
            end
         end
      end
   end

   always_comb begin
      ev = 7'h00;
      ev[`PSCSI_EV_DONE] = xs_q == X_WAIT && !f_q.ack;
      ev[`PSCSI_EV_PERR] = xs_q == X_HAND && f_q.ack && !in_ph && perr;
      ev[`PSCSI_EV_WIN] = arb_cnt_q == 16'h0001 && !pscsi_outranked(f_q.db, id);
      ev[`PSCSI_EV_LOSE] = arb_cnt_q == 16'h0001 && pscsi_outranked(f_q.db, id);
      ev[`PSCSI_EV_BRST] = f_q.rst && !rst_seen_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xs_q <= X_IDLE;
         tx_q <= 18'h0_0000;
         rx_q <= 17'h0_0000;
      end else begin
         case (xs_q)
            X_IDLE: begin
               if (tx_wr && act_ph && !f_q.rst) begin
                  tx_q <= hwdata[17:0];
                  xs_q <= X_SETUP;
               end
            end
            X_SETUP: xs_q <= X_HAND;
            X_HAND: begin
               if (f_q.ack) begin
                  if (!in_ph) begin
                     rx_q <= {perr, f_q.db};
                  end
                  xs_q <= X_WAIT;
               end
            end
            X_WAIT: begin
               if (!f_q.ack) begin
                  xs_q <= X_IDLE;
               end
            end
            default: xs_q <= X_IDLE;
         endcase
         if (f_q.rst) begin
            xs_q <= X_IDLE;
         end
      end
   end

   // ******************************************
   // Line drivers
   // ******************************************
   always_comb begin
      o_d = '0;
      oe_d = '1;
      o_d.rst = 1'b1;
      oe_d.rst = ~ctrl_q[`PSCSI_CTRL_RST];
      o_d.bsy = 1'b1;
      oe_d.bsy = phase_q == PH_BUS_FREE;
      if (arb_ph && arb_cnt_q != 16'h0000) begin
         o_d.db = 16'h0001 << id;
         oe_d.db = ~(16'h0001 << id);
      end
      if (act_ph) begin
         o_d.cd = !data_ph;
         o_d.io = in_ph;
         o_d.msg = phase_q == PH_MSG_IN || phase_q == PH_MSG_OUT;
         o_d.req = xs_q == X_HAND;
         {oe_d.cd, oe_d.io, oe_d.msg, oe_d.req} = 4'h0;
         if (in_ph) begin
            o_d.db[7:0] = tx_q[7:0];
            oe_d.db[7:0] = 8'h00;
            if (wide && data_ph) begin
               o_d.db[15:8] = tx_q[15:8];
               oe_d.db[15:8] = 8'h00;
               o_d.p1 = (dt_ph && (dg || iu)) ? 1'b0 : pscsi_par(tx_q[15:8]);
               oe_d.p1 = 1'b0;
            end
         end
         if (dt_ph) begin
            oe_d.p_crca = 1'b0;
            if (dg) begin
               o_d.p_crca = tx_q[`PSCSI_TX_PAD];
            end else if (iu) begin
               o_d.p_crca = xs_q != X_IDLE && tx_q[`PSCSI_TX_LAST] &&
                  ((phase_q == PH_DT_OUT && ctrl_q[`PSCSI_CTRL_WFC]) ||
                   (phase_q == PH_DT_IN && ctrl_q[`PSCSI_CTRL_RS]));
            end
         end else if (in_ph) begin
            o_d.p_crca = pscsi_par(tx_q[7:0]);
            oe_d.p_crca = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         o_q <= '0;
         oe_q <= '1;
      end else begin
         o_q <= o_d;
         oe_q <= oe_d;
      end
   end

   assign link.tgt_o = o_q;
   assign link.tgt_oe_n = oe_q;
endmodule

/* verilog/pscsi_map.svh */
// Register offsets, field positions, reset values and timing counts of the bus port.
`ifndef PSCSI_MAP_SVH
`define PSCSI_MAP_SVH
`define PSCSI_CTRL_OFS 8'h00
`define PSCSI_CMD_OFS 8'h04
`define PSCSI_TX_OFS 8'h08
`define PSCSI_RX_OFS 8'h0C
`define PSCSI_STATUS_OFS 8'h10
`define PSCSI_ISTAT_OFS 8'h14
`define PSCSI_IMASK_OFS 8'h18
`define PSCSI_ID_OFS 8'h1C
`define PSCSI_CTRL_DG 0
`define PSCSI_CTRL_IU 1
`define PSCSI_CTRL_WFC 2
`define PSCSI_CTRL_RS 3
`define PSCSI_CTRL_WIDE 4
`define PSCSI_CTRL_RST 5
`define PSCSI_CTRL_DT 6
`define PSCSI_TX_PAD 16
`define PSCSI_TX_LAST 17
`define PSCSI_EV_DONE 0
`define PSCSI_EV_PERR 1
`define PSCSI_EV_WIN 2
`define PSCSI_EV_LOSE 3
`define PSCSI_EV_BRST 4
`define PSCSI_EV_LAST 5
`define PSCSI_EV_PAD 6
`define PSCSI_CTRL_RESET 7'h00
`define PSCSI_MASK_RESET 7'h00
`define PSCSI_ID_RESET 4'h7
`define PSCSI_CLK_NS 10
`define PSCSI_ARB_NS 2400
`endif

/* verilog/pscsi_pkg.sv */
// Shared types and helper functions of both bus ends.
package pscsi_pkg;
   typedef struct packed {
      logic rst;
      logic bsy;
      logic sel;
      logic cd;
      logic io;
      logic msg;
      logic req;
      logic ack;
      logic atn;
      logic p_crca;
      logic p1;
      logic [15:0] db;
   } pscsi_bus_type;
   typedef enum logic [3:0] {
      PH_BUS_FREE, PH_ARB, PH_COMMAND, PH_MSG_OUT, PH_MSG_IN, PH_STATUS,
      PH_ST_IN, PH_ST_OUT, PH_DT_IN, PH_DT_OUT
   } pscsi_phase_type;
   typedef enum logic [1:0] {X_IDLE, X_SETUP, X_HAND, X_WAIT} pscsi_xfer_type;
   // Odd parity bit for a byte.
   function automatic logic pscsi_par(logic [7:0] b);
      return ~^b;
   endfunction
   // High when a received byte plus its parity bit holds an even count of ones.
   function automatic logic pscsi_par_bad(logic [7:0] b, logic p);
      return ~^{b, p};
   endfunction
   // Arbitration rank: line 7 is 15, line 0 is 8, line 15 is 7, line 8 is 0.
   function automatic logic [3:0] pscsi_rank(logic [3:0] i);
      return i[3] ? {1'b0, i[2:0]} : {1'b1, i[2:0]};
   endfunction
   function automatic logic pscsi_outranked(logic [15:0] db, logic [3:0] id);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (db[i] && pscsi_rank(4'(i)) > pscsi_rank(id)) begin
            r = 1'b1;
         end
      end
      return r;
   endfunction
endpackage

/* verilog/pscsi_if.sv */
// Shared bus between target and initiator with wired resolution of every line.
`timescale 1ns/1ps
interface pscsi_if import pscsi_pkg::*; ();
   pscsi_bus_type tgt_o;
   pscsi_bus_type tgt_oe_n;
   pscsi_bus_type ini_o;
   pscsi_bus_type ini_oe_n;
   pscsi_bus_type bus;
   // A released line falls false through the terminator bias.
   assign bus = (tgt_o & ~tgt_oe_n) | (ini_o & ~ini_oe_n);
   modport tgt (output tgt_o, output tgt_oe_n, input bus);
   modport ini (output ini_o, output ini_oe_n, input bus);
endinterface

/* verilog/pscsi_initiator.sv */
// Initiator end: receives and acknowledges transfers, checks parity, monitors P_CRCA.
`timescale 1ns/1ps
`include "pscsi_map.svh"
module pscsi_initiator import pscsi_pkg::*; #(
   parameter int ARB_CYCLES = (`PSCSI_ARB_NS + `PSCSI_CLK_NS - 1) / `PSCSI_CLK_NS
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Interrupt
   output logic irq,
   // Bus
   pscsi_if.ini link
);
   // ******************************************
   // Register port
   // ******************************************
   logic acc, wr_q, rst_seen_q;
   logic [7:0] wa_q;
   logic [6:0] ctrl_q, stat_q, mask_q, ev;
   logic [3:0] id_q;
   logic [15:0] tx_q, arb_cnt_q;
   logic [17:0] rx_q;
   logic [31:0] rd;
   pscsi_xfer_type xs_q;
   pscsi_bus_type s1_q, s2_q, s3_q, f_q, o_q, oe_q, o_d, oe_d;
   logic wide, dg, iu, dt, ph_data, act, perr, pad, last, lost;

   assign acc = hsel & htrans[1] & hready;

   always_comb begin
      case (haddr[7:0])
         `PSCSI_CTRL_OFS: rd = {25'h000_0000, ctrl_q};
         `PSCSI_TX_OFS: rd = {16'h0000, tx_q};
         `PSCSI_RX_OFS: rd = {14'h0000, rx_q};
         `PSCSI_STATUS_OFS: rd = {26'h000_0000, f_q.cd, f_q.io, f_q.msg, f_q.bsy,
                                  arb_cnt_q != 16'h0000, xs_q != X_IDLE};
         `PSCSI_ISTAT_OFS: rd = {25'h000_0000, stat_q};
         `PSCSI_IMASK_OFS: rd = {25'h000_0000, mask_q};
         `PSCSI_ID_OFS: rd = {28'h000_0000, id_q};
         default: rd = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_q <= acc & hwrite;
         if (acc) begin
            wa_q <= haddr[7:0];
         end
         if (acc && !hwrite) begin
            hrdata <= rd;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `PSCSI_CTRL_RESET;
         mask_q <= `PSCSI_MASK_RESET;
         id_q <= `PSCSI_ID_RESET;
         tx_q <= 16'h0000;
      end else if (wr_q) begin
         case (wa_q)
            `PSCSI_CTRL_OFS: ctrl_q <= hwdata[6:0];
            `PSCSI_IMASK_OFS: mask_q <= hwdata[6:0];
            `PSCSI_ID_OFS: id_q <= hwdata[3:0];
            `PSCSI_TX_OFS: tx_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Set wins over a clear arriving in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= 7'h00;
         irq <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~((wr_q && wa_q == `PSCSI_ISTAT_OFS) ? hwdata[6:0] : 7'h00)) | ev;
         irq <= |(stat_q & mask_q);
      end
   end

   // ******************************************
   // Input filtering and decode
   // ******************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         f_q <= '0;
      end else begin
         s1_q <= link.bus;
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
      end
   end

   assign wide = ctrl_q[`PSCSI_CTRL_WIDE];
   assign dg = ctrl_q[`PSCSI_CTRL_DG];
   assign iu = ctrl_q[`PSCSI_CTRL_IU];
   assign ph_data = !f_q.cd && !f_q.msg;
   assign dt = ph_data && ctrl_q[`PSCSI_CTRL_DT];
   assign act = f_q.bsy && !f_q.sel && arb_cnt_q == 16'h0000;
   assign perr = (!dt && pscsi_par_bad(f_q.db[7:0], f_q.p_crca)) ||
                 (wide && ph_data && !(dt && (dg || iu)) &&
                  pscsi_par_bad(f_q.db[15:8], f_q.p1));
   assign pad = dt && dg && f_q.p_crca;
   assign last = dt && iu && f_q.p_crca && (f_q.io ? ctrl_q[`PSCSI_CTRL_RS]
                                                   : ctrl_q[`PSCSI_CTRL_WFC]);
   assign lost = pscsi_outranked(f_q.db, id_q);

   always_comb begin
      ev = 7'h00;
      ev[`PSCSI_EV_DONE] = xs_q == X_IDLE && act && f_q.req && f_q.io && !pad;
      ev[`PSCSI_EV_PERR] = xs_q == X_IDLE && act && f_q.req && f_q.io && !pad && perr;
      ev[`PSCSI_EV_WIN] = arb_cnt_q == 16'h0001 && !lost;
      ev[`PSCSI_EV_LOSE] = arb_cnt_q == 16'h0001 && lost;
      ev[`PSCSI_EV_BRST] = f_q.rst && !rst_seen_q;
      ev[`PSCSI_EV_LAST] = xs_q == X_IDLE && act && f_q.req && last;
      ev[`PSCSI_EV_PAD] = xs_q == X_IDLE && act && f_q.req && f_q.io && pad;
   end

   // ******************************************
   // Arbitration and handshake
   // ******************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         arb_cnt_q <= 16'h0000;
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= f_q.rst;
         if (f_q.rst) begin
            arb_cnt_q <= 16'h0000;
         end else if (arb_cnt_q != 16'h0000) begin
            arb_cnt_q <= arb_cnt_q - 16'h0001;
         end else if (wr_q && wa_q == `PSCSI_CMD_OFS && hwdata[0] && !f_q.bsy) begin
            arb_cnt_q <= 16'(ARB_CYCLES);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xs_q <= X_IDLE;
         rx_q <= 18'h0_0000;
      end else begin
         case (xs_q)
            X_IDLE: begin
               if (act && f_q.req) begin
                  if (f_q.io) begin
                     if (!pad) begin
                        rx_q <= {perr, last, f_q.db};
                     end
                     xs_q <= X_HAND;
                  end else begin
                     xs_q <= X_SETUP;
                  end
               end
            end
            X_SETUP: xs_q <= X_HAND;
            X_HAND: begin
               if (!f_q.req) begin
                  xs_q <= X_IDLE;
               end
            end
            default: xs_q <= X_IDLE;
         endcase
         if (f_q.rst) begin
            xs_q <= X_IDLE;
         end
      end
   end

   // ******************************************
   // Line drivers
   // ******************************************
   always_comb begin
      o_d = '0;
      oe_d = '1;
      o_d.rst = 1'b1;
      oe_d.rst = ~ctrl_q[`PSCSI_CTRL_RST];
      if (arb_cnt_q != 16'h0000) begin
         o_d.bsy = 1'b1;
         oe_d.bsy = 1'b0;
         o_d.db = 16'h0001 << id_q;
         oe_d.db = ~(16'h0001 << id_q);
      end
      if (act) begin
         o_d.ack = xs_q == X_HAND;
         oe_d.ack = 1'b0;
         if (!f_q.io && xs_q != X_IDLE) begin
            o_d.db[7:0] = tx_q[7:0];
            oe_d.db[7:0] = 8'h00;
            if (!dt) begin
               o_d.p_crca = pscsi_par(tx_q[7:0]);
               oe_d.p_crca = 1'b0;
            end
            if (wide && ph_data) begin
               o_d.db[15:8] = tx_q[15:8];
               oe_d.db[15:8] = 8'h00;
               o_d.p1 = (dt && (dg || iu)) ? 1'b0 : pscsi_par(tx_q[15:8]);
               oe_d.p1 = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         o_q <= '0;
         oe_q <= '1;
      end else begin
         o_q <= o_d;
         oe_q <= oe_d;
      end
   end

   assign link.ini_o = o_q;
   assign link.ini_oe_n = oe_q;
endmodule

/* bench/pscsi_properties.sv */
// Concurrent checks on the bus joining target and initiator.
`timescale 1ns/1ps
module pscsi_properties import pscsi_pkg::*; (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Drivers and resolved lines
   input wire pscsi_bus_type tgt_o,
   input wire pscsi_bus_type tgt_oe_n,
   input wire pscsi_bus_type ini_o,
   input wire pscsi_bus_type ini_oe_n,
   input wire pscsi_bus_type bus
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   single_driver_a: assert property (
      (~tgt_oe_n.db & ~ini_oe_n.db) == 16'h0000 && ini_oe_n.req && ini_oe_n.cd && tgt_oe_n.ack)
      else $error("Two drivers on one bus line.");
   or_tied_a: assert property (
      (tgt_oe_n.bsy | tgt_o.bsy) & (tgt_oe_n.rst | tgt_o.rst) & (tgt_oe_n.sel | tgt_o.sel)
      & (ini_oe_n.bsy | ini_o.bsy) & (ini_oe_n.rst | ini_o.rst) & (ini_oe_n.sel | ini_o.sel))
      else $error("OR-tied line driven false.");
   upper_parity_a: assert property (!tgt_oe_n.p1 && tgt_o.p1 |-> !(^tgt_o.db[15:8]))
      else $error("Upper byte parity not odd.");
   control_p1_a: assert property (bus.cd |-> tgt_oe_n.p1 && ini_oe_n.p1)
      else $error("Upper parity driven in a control phase.");
   arb_parity_a: assert property (!ini_oe_n.bsy |->
      (ini_oe_n.p_crca | ini_o.p_crca) && (ini_oe_n.p1 | ini_o.p1))
      else $error("Parity line driven false in arbitration.");
   ack_after_req_a: assert property ($rose(bus.ack) |-> bus.req && bus.bsy)
      else $error("Acknowledge without request.");
   ack_release_a: assert property (bus.ack && !bus.req |-> ##[1:12] !bus.ack)
      else $error("Acknowledge held after request fell.");
   data_hold_a: assert property (bus.req && $past(bus.req) && bus.io |->
      $stable(tgt_o.db) && $stable(tgt_o.p_crca) && $stable(tgt_o.p1))
      else $error("Target data moved during handshake.");
   reset_abort_a: assert property ($rose(bus.rst) |-> ##[1:12] !bus.bsy && !bus.cd)
      else $error("Bus reset did not free the bus.");
   cover property (bus.req && bus.p_crca);
   cover property ($rose(bus.rst));
   cover property (!ini_oe_n.bsy && !tgt_oe_n.bsy);
endmodule

/* bench/parallel_scsi_parity_signal_control_tb.sv */
// Testbench driving both bus ends through their register ports.
`timescale 1ns/1ps
module parallel_scsi_parity_signal_control_tb import pscsi_pkg::*;;
   logic hclk = 0;
   logic hresetn = 0;
   logic tsel = 0;
   logic isel = 0;
   logic hwrite = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0;
   logic [31:0] hwdata = 0;
   logic [31:0] rd;
   logic mask_on = 0;
   wire t_rdy, i_rdy, t_resp, i_resp, t_irq, i_irq;
   wire [31:0] t_rd, i_rd;
   wire hready = t_rdy & i_rdy;
   int n_fail = 0;
   int comparisons = 0;
   pscsi_bus_type seen;
   pscsi_if link ();
   // Jumper value above 7 so narrow and wide readings differ.
   pscsi_target #(.ARB_CYCLES(16)) pscsi_target_inst (.hclk(hclk), .hresetn(hresetn),
      .hsel(tsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(t_rdy), .hresp(t_resp), .hrdata(t_rd),
      .irq(t_irq), .id_jumper(4'hb), .link(link.tgt));
   pscsi_initiator #(.ARB_CYCLES(16)) pscsi_initiator_inst (.hclk(hclk), .hresetn(hresetn),
      .hsel(isel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(i_rdy), .hresp(i_resp), .hrdata(i_rd),
      .irq(i_irq), .link(link.ini));
   pscsi_properties pscsi_properties_inst (.hclk(hclk), .hresetn(hresetn), .tgt_o(link.tgt_o),
      .tgt_oe_n(link.tgt_oe_n), .ini_o(link.ini_o), .ini_oe_n(link.ini_oe_n), .bus(link.bus));
   initial forever #5 hclk = ~hclk;
   always @(posedge hclk) if (link.bus.req) seen <= link.bus;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic ahb(input logic dv, input logic [7:0] a, input logic w, input logic [31:0] wd);
      int k = 0;
      @(posedge hclk);
      tsel <= !dv;
      isel <= dv;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1 && ++k < 99);
      tsel <= 1'b0;
      isel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1 && ++k < 99);
      rd = dv ? i_rd : t_rd;
      if (k >= 99) begin
         $display("ERROR hready expected 1 seen %b", hready);
         n_fail++;
         final_report();
      end
   endtask
   task automatic wr(input logic dv, input logic [7:0] a, input logic [31:0] d);
      ahb(dv, a, 1'b1, d);
   endtask
   task automatic rc(input logic dv, input logic [7:0] a, input logic [31:0] e, input string nm);
      ahb(dv, a, 1'b0, '0);
      chk(nm, e, rd);
   endtask
   task automatic poll(input logic dv, input logic [7:0] a, input logic [31:0] m);
      for (int k = 0; k < 200; k++) begin
         ahb(dv, a, 1'b0, '0);
         if ((rd & m) != 0) return;
      end
      $display("ERROR poll %h expected %h seen %h", a, m, rd);
      n_fail++;
      final_report();
   endtask
   task automatic xfer(input logic [6:0] c, input logic [3:0] ph, input logic [31:0] tx);
      wr(0, 8'h00, {25'h0, c});
      wr(1, 8'h00, {25'h0, c});
      wr(0, 8'h04, {28'h0, ph});
      wr(1, 8'h08, tx);
      wr(0, 8'h08, tx);
      poll(0, 8'h14, 32'h0000_0001);
      ahb(0, 8'h1c, 1'b0, '0);
      chk("irq set", mask_on, t_irq);
      wr(0, 8'h14, 32'h0000_007f);
      rc(0, 8'h14, '0, "istat clear");
      chk("irq clear", 1'b0, t_irq);
      chk("resp irq", '0, {t_resp, i_resp, i_irq});
   endtask
   task automatic t_st;
      logic [15:0] d [2] = '{16'h0301, 16'hfe80};
      rc(0, 8'h1c, 32'h0000_0003, "narrow id");
      rc(1, 8'h1c, 32'h0000_0007, "ini id");
      rc(0, 8'h40, '0, "unmapped");
      wr(0, 8'h18, 32'h0000_0001);
      mask_on = 1'b1;
      foreach (d[i]) begin
         xfer(7'h10, 4'h6, {16'h0000, d[i]});
         chk("p1", ~^d[i][15:8], seen.p1);
         chk("p_crca", ~^d[i][7:0], seen.p_crca);
         chk("db", d[i], seen.db);
         rc(1, 8'h0c, {16'h0000, d[i]}, "ini rx");
      end
      rc(0, 8'h1c, 32'h0000_000b, "wide id");
      wr(0, 8'h18, '0);
      mask_on = 1'b0;
      $display("st test done");
   endtask
   task automatic t_dt;
      logic [6:0] c [3] = '{7'h5a, 7'h52, 7'h56};
      logic [3:0] p [3] = '{4'h8, 4'h8, 4'h9};
      logic e [3] = '{1'b1, 1'b0, 1'b1};
      xfer(7'h51, 4'h8, 32'h0001_00ff);
      chk("pad flag", 1'b1, seen.p_crca);
      chk("dg p1", 1'b0, seen.p1);
      rc(1, 8'h0c, 32'h0000_fe80, "pad kept out");
      xfer(7'h51, 4'h8, 32'h0000_00ff);
      chk("data flag", 1'b0, seen.p_crca);
      rc(1, 8'h0c, 32'h0000_00ff, "dg rx");
      for (int i = 0; i < 3; i++) begin
         xfer(c[i], p[i], 32'h0002_0000);
         chk("last flag", e[i], seen.p_crca);
         chk("iu p1", 1'b0, seen.p1);
      end
      $display("dt test done");
   endtask
   task automatic t_arb;
      wr(0, 8'h00, '0);
      wr(0, 8'h04, '0);
      wr(1, 8'h14, 32'h0000_007f);
      wr(0, 8'h14, 32'h0000_007f);
      wr(1, 8'h04, 32'h0000_0001);
      wr(0, 8'h04, 32'h0000_0001);
      poll(0, 8'h14, 32'h0000_000c);
      rc(0, 8'h14, 32'h0000_0008, "tgt lost");
      rc(1, 8'h14, 32'h0000_0004, "ini won");
      wr(0, 8'h04, 32'h0000_0002);
      wr(0, 8'h00, 32'h0000_0020);
      poll(1, 8'h14, 32'h0000_0010);
      poll(0, 8'h14, 32'h0000_0010);
      rc(0, 8'h04, '0, "phase after reset");
      wr(0, 8'h00, '0);
      $display("arb test done");
   endtask
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      t_st();
      t_dt();
      t_arb();
      final_report();
   end
endmodule
